// ---- verilog/art_control.sv ----
// Converter control: registers, result pair, trigger logic, pin disables
`default_nettype none
module art_control
    import art_pkg::*;
#(
    parameter int PIN_COUNT = 11
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [10:0] conv_raw,
    input wire logic conv_done,
    input wire logic [7:1] trig_flags,
    input wire logic [PIN_COUNT-1:0] pin_raw,
    output logic [PIN_COUNT-1:0] pin_read,
    output logic [PIN_COUNT-1:0] pin_buffer_off,
    output logic conv_start,
    output logic converter_enable,
    output logic bipolar_select,
    output logic conv_clk,
    output logic external_reference_enable,
    output logic reference_output_enable,
    output logic comparator_mux_enable,
    output logic [CMP_REF_W-1:0] comparator_ref_select
);
    // ========================================================================
    // Elaboration checks
    // Eight pins sit in register 0 and one to three in register 1
    if (PIN_COUNT < 9 || PIN_COUNT > 11) begin : g_bad_pins
        $error("art_control: PIN_COUNT must lie between 9 and 11");
    end

    // ========================================================================
    // Declarations
    logic [DIV_W-1:0] clock_divide_select;
    logic result_left_align;
    logic auto_trigger_enable;
    logic conversion_done_flag;
    logic busy;
    logic [TRIG_W-1:0] trigger_source_select;
    logic [7:0] low_pin_input_disable;
    logic [DIS1_W-1:0] high_pin_input_disable;
    logic [9:0] result;
    logic result_lock;
    logic trig_prev;
    logic trig_sel;
    logic trig_edge;
    logic sw_start;
    logic start_now;
    logic [9:0] next_result;
    logic [7:0] high_view;
    logic [7:0] low_view;
    logic [7:0] next_rdata;
    logic [PIN_COUNT-1:0] sync_a;
    logic [PIN_COUNT-1:0] sync_b;
    logic [PIN_COUNT-1:0] sync_c;
    logic [PIN_COUNT-1:0] pin_stable;
    logic [PIN_COUNT-1:0] disable_mask;
    logic wr_ca;
    logic wr_cb;
    logic rd_low;
    logic rd_high;

    // ========================================================================
    // Address decode
    assign wr_ca = reg_write && (reg_addr == ADDR_CTRL_A);
    assign wr_cb = reg_write && (reg_addr == ADDR_CTRL_B);
    assign rd_low = reg_read && (reg_addr == ADDR_RES_LOW);
    assign rd_high = reg_read && (reg_addr == ADDR_RES_HIGH);
    assign sw_start = wr_ca && reg_wdata[CA_START];

    // ========================================================================
    // Control A: enable, start, auto trigger, align, divider
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            converter_enable <= 1'b0;
            auto_trigger_enable <= 1'b0;
            result_left_align <= 1'b0;
            clock_divide_select <= REG_RESET[DIV_W-1:0];
        end else if (ce && wr_ca) begin
            converter_enable <= reg_wdata[CA_ENABLE];
            auto_trigger_enable <= reg_wdata[CA_AUTO];
            result_left_align <= reg_wdata[CA_ALIGN];
            clock_divide_select <= reg_wdata[CA_DIV_LSB +: DIV_W];
        end
    end

    // Done flag: write one clears, but a completion in the same cycle wins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            conversion_done_flag <= 1'b0;
        end else if (ce) begin
            if (conv_done) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_ca && reg_wdata[CA_DONE]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // Busy follows a start until completion or until the converter stops
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else if (ce) begin
            if (!converter_enable || conv_done) begin
                busy <= 1'b0;
            end else if (start_now) begin
                busy <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Control B: polarity, comparator fields, trigger source
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bipolar_select <= 1'b0;
            comparator_mux_enable <= 1'b0;
            comparator_ref_select <= REG_RESET[CMP_REF_W-1:0];
            trigger_source_select <= TRIG_FREE_RUN;
        end else if (ce && wr_cb) begin
            bipolar_select <= reg_wdata[CB_BIPOLAR];
            comparator_mux_enable <= reg_wdata[CB_CMP_MUX];
            comparator_ref_select <= reg_wdata[CB_CMP_REF_LSB +: CMP_REF_W];
            // Bit 3 is not stored, so it always reads back as zero
            trigger_source_select <= reg_wdata[CB_TRIG_LSB +: TRIG_W];
        end
    end

    // ========================================================================
    // Disable and misc registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            low_pin_input_disable <= REG_RESET;
            high_pin_input_disable <= REG_RESET[DIS1_W-1:0];
            external_reference_enable <= 1'b0;
            reference_output_enable <= 1'b0;
        end else if (ce && reg_write) begin
            if (reg_addr == ADDR_DIS0) begin
                low_pin_input_disable <= reg_wdata;
            end
            if (reg_addr == ADDR_DIS1) begin
                // Reserved bits are dropped so they cannot steer anything
                high_pin_input_disable <= reg_wdata[DIS1_LSB +: DIS1_W];
            end
            if (reg_addr == ADDR_MISC) begin
                external_reference_enable <= reg_wdata[MISC_EXT_REF];
                reference_output_enable <= reg_wdata[MISC_REF_OUT];
            end
        end
    end

    // ========================================================================
    // Trigger selection and edge detection
    // Free running watches the done flag, so a completion retriggers only once the flag has been cleared
    always_comb begin
        case (art_trig_t'(trigger_source_select))
            ART_TRIG_FREE: trig_sel = conversion_done_flag;
            ART_TRIG_CMP: trig_sel = trig_flags[1];
            ART_TRIG_EXT0: trig_sel = trig_flags[2];
            ART_TRIG_T1_CMPA: trig_sel = trig_flags[3];
            ART_TRIG_T1_OVF: trig_sel = trig_flags[4];
            ART_TRIG_T1_CMPB: trig_sel = trig_flags[5];
            ART_TRIG_T1_CAPT: trig_sel = trig_flags[6];
            ART_TRIG_WDOG: trig_sel = trig_flags[7];
            default: trig_sel = 1'b0;
        endcase
    end

    // The previous level is of the mux output, so a source swap from a clear
    // flag to a set one looks like a rising edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            trig_prev <= 1'b0;
        end else if (ce) begin
            trig_prev <= trig_sel;
        end
    end

    // A swap into free running is masked, even with the done flag set
    always_comb begin
        trig_edge = trig_sel && !trig_prev;
        if (wr_cb && reg_wdata[CB_TRIG_LSB +: TRIG_W] == TRIG_FREE_RUN
            && trigger_source_select != TRIG_FREE_RUN) begin
            trig_edge = 1'b0;
        end
    end

    // Register write of the free running code is seen one cycle late on the
    // mux, so the mask is held with the previous source value
    logic free_swap;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            free_swap <= 1'b0;
        end else if (ce) begin
            free_swap <= wr_cb && !trig_edge
                && reg_wdata[CB_TRIG_LSB +: TRIG_W] == TRIG_FREE_RUN
                && trigger_source_select != TRIG_FREE_RUN;
        end
    end

    // Start decision: source field ignored unless auto trigger is on
    assign start_now = converter_enable && !busy
        && (sw_start
            || (auto_trigger_enable && trig_edge && !free_swap));

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            conv_start <= 1'b0;
        end else if (ce) begin
            conv_start <= start_now;
        end
    end

    // ========================================================================
    // Result formatting
    // Raw value is the signed difference of the inputs in eleven bits
    always_comb begin
        if (!bipolar_select) begin
            if (conv_raw[10] || conv_raw == 11'h000) begin
                next_result = UNI_SATURATE;
            end else begin
                next_result = conv_raw[9:0];
            end
        end else begin
            // Clamp to nine magnitude bits plus sign
            if (conv_raw[10] && !conv_raw[9]) begin
                next_result = 10'h200;
            end else if (!conv_raw[10] && conv_raw[9]) begin
                next_result = 10'h1ff;
            end else begin
                next_result = conv_raw[9:0];
            end
        end
    end

    // ========================================================================
    // Result store and read order lock
    // A completion while locked, or beside a low read, is lost; the flag
    // still reports it, and the halves software reads stay one result
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            result <= RESULT_RESET;
        end else if (ce && conv_done && !result_lock && !rd_low) begin
            result <= next_result;
        end
    end

    // A low byte read locks and wins over a same-cycle high byte read, which releases
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            result_lock <= 1'b0;
        end else if (ce) begin
            if (rd_low) begin
                result_lock <= 1'b1;
            end else if (rd_high) begin
                result_lock <= 1'b0;
            end
        end
    end

    // Views are combinational so an alignment change shows at once
    always_comb begin
        if (result_left_align) begin
            high_view = result[9:2];
            low_view = {result[1:0], 6'h00};
        end else begin
            high_view = {6'h00, result[9:8]};
            low_view = result[7:0];
        end
    end

    // ========================================================================
    // Read data mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            ADDR_RES_LOW: next_rdata = low_view;
            ADDR_RES_HIGH: next_rdata = high_view;
            ADDR_CTRL_A: begin
                next_rdata[CA_ENABLE] = converter_enable;
                next_rdata[CA_START] = busy;
                next_rdata[CA_AUTO] = auto_trigger_enable;
                next_rdata[CA_DONE] = conversion_done_flag;
                next_rdata[CA_ALIGN] = result_left_align;
                next_rdata[CA_DIV_LSB +: DIV_W] = clock_divide_select;
            end
            ADDR_CTRL_B: begin
                next_rdata[CB_BIPOLAR] = bipolar_select;
                next_rdata[CB_CMP_MUX] = comparator_mux_enable;
                next_rdata[CB_CMP_REF_LSB +: CMP_REF_W] = comparator_ref_select;
                next_rdata[CB_TRIG_LSB +: TRIG_W] = trigger_source_select;
            end
            ADDR_DIS0: next_rdata = low_pin_input_disable;
            ADDR_DIS1: next_rdata[DIS1_LSB +: DIS1_W] = high_pin_input_disable;
            ADDR_MISC: begin
                next_rdata[MISC_EXT_REF] = external_reference_enable;
                next_rdata[MISC_REF_OUT] = reference_output_enable;
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
        end
    end

    // ========================================================================
    // Pin input path: three stage synchroniser, change taken on agreement
    assign disable_mask = PIN_COUNT'({high_pin_input_disable,
                                      low_pin_input_disable});

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
            pin_stable <= '0;
        end else if (ce) begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
            // Only bits where stages two and three agree move
            pin_stable <= (pin_stable & ~(sync_b ~^ sync_c))
                | (sync_b & (sync_b ~^ sync_c));
        end
    end

    // Disabled pins read zero and their buffers are shut off
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_read <= '0;
            pin_buffer_off <= '0;
        end else if (ce) begin
            pin_read <= pin_stable & ~disable_mask;
            pin_buffer_off <= disable_mask;
        end
    end

    // ========================================================================
    // Converter clock prescaler
    art_prescaler u_prescaler (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .divide_select(clock_divide_select),
        .conv_clk(conv_clk)
    );

endmodule : art_control
`default_nettype wire

// ---- verilog/art_pkg.sv ----
// Package: register map, field layout and reset values of the converter
`default_nettype none
package art_pkg;
    // ========================================================================
    // Register offsets
    localparam logic [7:0] ADDR_MISC = 8'h77;
    localparam logic [7:0] ADDR_RES_LOW = 8'h78;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h79;
    localparam logic [7:0] ADDR_CTRL_A = 8'h7a;
    localparam logic [7:0] ADDR_CTRL_B = 8'h7b;
    localparam logic [7:0] ADDR_DIS0 = 8'h7e;
    localparam logic [7:0] ADDR_DIS1 = 8'h7f;

    // ========================================================================
    // Control A fields
    localparam int CA_ENABLE = 7;
    localparam int CA_START = 6;
    localparam int CA_AUTO = 5;
    localparam int CA_DONE = 4;
    localparam int CA_ALIGN = 3;
    localparam int CA_DIV_LSB = 0;
    localparam int DIV_W = 3;

    // ========================================================================
    // Control B fields
    localparam int CB_BIPOLAR = 7;
    localparam int CB_CMP_MUX = 6;
    localparam int CB_CMP_REF_LSB = 4;
    localparam int CMP_REF_W = 2;
    localparam int CB_TRIG_LSB = 0;
    localparam int TRIG_W = 3;

    // ========================================================================
    // Disable register 1 and misc register fields
    localparam int DIS1_LSB = 4;
    localparam int DIS1_W = 3;
    localparam int MISC_EXT_REF = 2;
    localparam int MISC_REF_OUT = 1;

    // ========================================================================
    // Reset values and constants
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] UNI_SATURATE = 10'h3ff;
    localparam logic [TRIG_W-1:0] TRIG_FREE_RUN = 3'h0;
    // Division is 2 to the power of the field, codes below this give this
    localparam logic [DIV_W-1:0] DIV_SHIFT_MIN = 3'h1;

    // Trigger source codes
    typedef enum logic [TRIG_W-1:0] {
        ART_TRIG_FREE = 3'h0,
        ART_TRIG_CMP = 3'h1,
        ART_TRIG_EXT0 = 3'h2,
        ART_TRIG_T1_CMPA = 3'h3,
        ART_TRIG_T1_OVF = 3'h4,
        ART_TRIG_T1_CMPB = 3'h5,
        ART_TRIG_T1_CAPT = 3'h6,
        ART_TRIG_WDOG = 3'h7
    } art_trig_t;
endpackage : art_pkg
`default_nettype wire

// ---- verilog/art_prescaler.sv ----
// Converter clock prescaler: free running divider of the system clock
`default_nettype none
module art_prescaler
    import art_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [DIV_W-1:0] divide_select,
    output logic conv_clk
);
    // ========================================================================
    // Half period terminal count
    logic [6:0] count;
    logic [6:0] terminal;
    logic [DIV_W-1:0] shift;

    // Codes 0 and 1 both divide by 2, higher codes by 2 to the code
    always_comb begin
        shift = (divide_select < DIV_SHIFT_MIN) ? DIV_SHIFT_MIN
                                                : divide_select;
        terminal = 7'((8'h01 << (shift - DIV_SHIFT_MIN)) - 8'h01);
    end

    // ========================================================================
    // Counter never stops so the phase is stable across divider changes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            count <= 7'h00;
            conv_clk <= 1'b0;
        end else if (ce) begin
            if (count >= terminal) begin
                count <= 7'h00;
                conv_clk <= ~conv_clk;
            end else begin
                count <= count + 7'h01;
            end
        end
    end
endmodule : art_prescaler
`default_nettype wire

// ---- verif/art_control_assertions.sv ----
// Checker: port-level properties of the converter control block
`default_nettype none
module art_checker
    import art_pkg::*;
#(
    parameter int PIN_COUNT = 11
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [PIN_COUNT-1:0] pin_read,
    input wire logic [PIN_COUNT-1:0] pin_buffer_off,
    input wire logic conv_start,
    input wire logic converter_enable,
    input wire logic external_reference_enable,
    input wire logic reference_output_enable
);
    // ==========
    // Alignment shadow; ignores ce, so only valid while ce stays high
    logic align;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            align <= 1'b0;
        end else if (reg_write && reg_addr == ADDR_CTRL_A) begin
            align <= reg_wdata[CA_ALIGN];
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ==========
    // Reserved and padding bits, pin masking, start pulse, reference enables
    a_ctrlb_bit_low: assert property (
        reg_read && reg_addr == ADDR_CTRL_B |=> !reg_rdata[3])
        else $error("control B bit 3 read as one");
    a_dis1_reserved_low: assert property (
        $past(reg_read) && $past(reg_addr) == ADDR_DIS1
        |-> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
        else $error("disable 1 reserved bits read as one");
    a_misc_reserved_low: assert property (
        reg_read && reg_addr == ADDR_MISC ##1 1'b1
        |-> reg_rdata[7:3] == 5'h00)
        else $error("misc reserved bits read as one");
    a_pin_read_masked: assert property (
        (pin_read & pin_buffer_off) == '0)
        else $error("disabled pin reads as one");
    a_start_one_cycle: assert property (
        $rose(conv_start) |=> $fell(conv_start))
        else $error("start pulse longer than one cycle");
    a_start_needs_enable: assert property (
        conv_start |-> converter_enable)
        else $error("start while converter disabled");
    a_ref_follows_write: assert property (
        reg_write && reg_addr == ADDR_MISC |=>
        external_reference_enable == $past(reg_wdata[MISC_EXT_REF]) &&
        reference_output_enable == $past(reg_wdata[MISC_REF_OUT]))
        else $error("reference enables do not follow write");
    a_right_high_pad: assert property (
        reg_read && reg_addr == ADDR_RES_HIGH && !align
        |=> reg_rdata[7:2] == 6'h00)
        else $error("right aligned high byte not padded");
    a_left_low_pad: assert property (
        reg_read && reg_addr == ADDR_RES_LOW && align
        |=> reg_rdata[5:0] == 6'h00)
        else $error("left aligned low byte not padded");
endmodule // art_checker

bind art_control art_checker #(.PIN_COUNT(PIN_COUNT)) u_checker (
    .mclk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .pin_read, .pin_buffer_off, .conv_start,
    .converter_enable, .external_reference_enable,
    .reference_output_enable);
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench: register bus, result formats, triggers, pins, prescaler
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top import art_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, conv_done = 1'b0;
    logic reg_write = 1'b0, reg_read = 1'b0, pend = 1'b0, pclk = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, e, d0, d1;
    logic [10:0] conv_raw = 11'h000, pin_raw = 11'h000, m;
    logic [10:0] pin_read, pin_buffer_off;
    logic [7:1] trig_flags = 7'h00;
    logic [8:0] per = 9'h000, pcnt = 9'h000;
    logic [9:0] r;
    logic conv_start, converter_enable, bipolar_select, conv_clk;
    logic external_reference_enable, reference_output_enable;
    logic comparator_mux_enable;
    logic [1:0] comparator_ref_select;
    logic [10:0] raws[4] = '{11'h000, 11'h5a8, 11'h7fb, 11'h2bc};
    int num_errors = 0, cmp_count = 0, cyc = 0, start_cnt = 0, i, c, s0;
    logic [7:0] exp_q[$];

    always #5 mclk = ~mclk;

    art_control #(.PIN_COUNT(11)) dut (.mclk, .rstn, .ce, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .conv_raw,
        .conv_done, .trig_flags, .pin_raw, .pin_read, .pin_buffer_off,
        .conv_start, .converter_enable, .bipolar_select, .conv_clk,
        .external_reference_enable, .reference_output_enable,
        .comparator_mux_enable, .comparator_ref_select);

    // ==========
    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Monitor: read answers against notes, start count, clock period
    always @(posedge mclk) begin
        if (pend) begin
            e = exp_q.pop_front();
            `CHK(reg_rdata, e)
        end
        pend = reg_read;
        if (conv_start) start_cnt++;
        pcnt++;
        if (conv_clk && !pclk) begin
            per = pcnt;
            pcnt = 9'h000;
        end
        pclk = conv_clk;
        if (++cyc == 10000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ==========
    // Bus tasks leave an idle cycle so a strobe is never re-set same step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk) reg_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk) reg_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic conv(input logic [10:0] raw);
        conv_raw <= raw;
        conv_done <= 1'b1;
        @(posedge mclk) conv_done <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [9:0] res(logic signed [10:0] v, logic b);
        if (!b) return (v <= 0) ? 10'h3ff : v[9:0];
        if (v > 511) return 10'h1ff;
        if (v < -512) return 10'h200;
        return v[9:0];
    endfunction
    function automatic logic [7:0] lo(logic [9:0] v, logic a);
        return a ? {v[1:0], 6'h00} : v[7:0];
    endfunction
    function automatic logic [7:0] hi(logic [9:0] v, logic a);
        return a ? v[9:2] : {6'h00, v[9:8]};
    endfunction

    // ==========
    initial begin
        i = $urandom(59153);
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        for (i = 8'h77; i <= 8'h7f; i++) rd(8'(i), 8'h00);
        rd(8'h00, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CTRL_A, 8'(i));
            repeat (300) @(posedge mclk);
            `CHK(per, 9'(1 << ((i < 1) ? 1 : i)))
        end
        // Edge values first, then random codes, in every mode
        for (i = 0; i < 8; i++) begin
            m = (i < 4) ? raws[i] : 11'($urandom);
            wr(ADDR_CTRL_B, {i[0], 7'h00});
            wr(ADDR_CTRL_A, {4'hc, i[1], 3'h0});
            conv(m);
            r = res(m, i[0]);
            `CHK(bipolar_select, i[0])
            rd(ADDR_RES_LOW, lo(r, i[1]));
            rd(ADDR_RES_HIGH, hi(r, i[1]));
            wr(ADDR_CTRL_A, {4'h8, ~i[1], 3'h0});
            rd(ADDR_RES_HIGH, hi(r, ~i[1]));
        end
        // A low read holds the pair until the high read
        wr(ADDR_CTRL_A, 8'hc0);
        conv(11'h123);
        rd(ADDR_RES_LOW, 8'h23);
        wr(ADDR_CTRL_A, 8'hc0);
        conv(11'h0ab);
        rd(ADDR_RES_HIGH, 8'h01);
        wr(ADDR_CTRL_A, 8'hc0);
        conv(11'h0ab);
        rd(ADDR_RES_LOW, 8'hab);
        rd(ADDR_RES_HIGH, 8'h00);
        for (c = 1; c < 8; c++) begin
            wr(ADDR_CTRL_B, 8'(c));
            wr(ADDR_CTRL_A, 8'ha0);
            s0 = start_cnt;
            trig_flags <= ~(7'h01 << (c - 1));
            repeat (4) @(posedge mclk);
            `CHK(start_cnt, s0)
            trig_flags <= 7'h7f;
            repeat (4) @(posedge mclk);
            `CHK(start_cnt, s0 + 1)
            conv(11'h001);
            trig_flags <= 7'h00;
        end
        wr(ADDR_CTRL_A, 8'h80);
        `CHK(converter_enable, 1'b1)
        s0 = start_cnt;
        trig_flags <= 7'h7f;
        repeat (4) @(posedge mclk);
        `CHK(start_cnt, s0)
        trig_flags <= 7'h04;
        wr(ADDR_CTRL_B, 8'h02);
        wr(ADDR_CTRL_A, 8'ha0);
        s0 = start_cnt;
        wr(ADDR_CTRL_B, 8'h03);
        repeat (4) @(posedge mclk);
        `CHK(start_cnt, s0 + 1)
        conv(11'h001);
        // Old source clear and done flag set: only the mask stops a start
        trig_flags <= 7'h00;
        s0 = start_cnt;
        wr(ADDR_CTRL_B, 8'h00);
        repeat (4) @(posedge mclk);
        `CHK(start_cnt, s0)
        // Clear the done flag, then a completion retriggers free running
        wr(ADDR_CTRL_A, 8'hb0);
        rd(ADDR_CTRL_A, 8'ha0);
        s0 = start_cnt;
        conv(11'h001);
        repeat (4) @(posedge mclk);
        `CHK(start_cnt, s0 + 1)
        wr(ADDR_CTRL_A, 8'h00);
        for (i = 0; i < 3; i++) begin
            d0 = 8'($urandom);
            d1 = 8'($urandom) & 8'h70;
            pin_raw <= 11'($urandom);
            wr(ADDR_DIS0, d0);
            wr(ADDR_DIS1, d1);
            repeat (6) @(posedge mclk);
            m = {d1[6:4], d0};
            `CHK(pin_buffer_off, m)
            `CHK(pin_read, pin_raw & ~m)
            rd(ADDR_DIS1, d1);
        end
        // Clock enable low freezes state, so this write must be lost
        ce <= 1'b0;
        wr(ADDR_DIS0, ~d0);
        ce <= 1'b1;
        rd(ADDR_DIS0, d0);
        wr(ADDR_MISC, 8'h06);
        rd(ADDR_MISC, 8'h06);
        `CHK(external_reference_enable, 1'b1)
        `CHK(reference_output_enable, 1'b1)
        wr(ADDR_CTRL_B, 8'h77);
        rd(ADDR_CTRL_B, 8'h77);
        `CHK({comparator_mux_enable, comparator_ref_select}, 3'h7)
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
